// File: cra_pkg.sv
package cra_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REF_RAMP_PAGE      = 8'h01;
    localparam logic [7:0] REF_RAMP_OFFSET    = 8'h08;
    localparam logic [7:0] BANK_CTRL_PAGE     = 8'h2c;
    localparam logic [7:0] BANK_CTRL_OFFSET   = 8'h01;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         REF_RAMP_FAST_BIT  = 4;
    localparam int         BANK_MONITOR_BIT   = 3;
    localparam int         ADAPTIVE_BIT       = 2;
    localparam int         ACTIVE_BANK_BIT    = 1;
    localparam int         SWITCH_REQ_BIT     = 0;
    localparam logic       REF_RAMP_FAST_RST  = 1'b0;
    localparam logic       ADAPTIVE_RST       = 1'b0;
    localparam logic       SWITCH_REQ_RST     = 1'b0;
    localparam logic       ACTIVE_BANK_RST    = 1'b0;

    // ------------------------------------------------------------------
    // Reference ramp times
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_PS      = 5000;
    localparam int         RAMP_NORMAL_MS     = 50;
    localparam int         RAMP_FAST_MS       = 1;
    // Cycles per millisecond are worked out first, so the product stays inside 32 bits.
    localparam int         RAMP_NORMAL_CYC    = RAMP_NORMAL_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int         RAMP_FAST_CYC      = RAMP_FAST_MS * (1000000000 / CLK_PERIOD_PS);

    typedef enum logic [1:0] {
        CRA_SW_IDLE = 2'b00,
        CRA_SW_WAIT = 2'b01,
        CRA_SW_DONE = 2'b11
    } cra_sw_state_t;

endpackage

// File: cra_bank_if.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Bank routing between the arbiter core and its access decoder
// ------------------------------------------------------------------
interface cra_bank_if;
    logic adaptive;
    logic dsp_run;
    logic active_bank;
    logic dsp_bank_sel;
    logic host_a_ok;
    logic host_b_ok;

    modport ctrl (output adaptive, output dsp_run, output active_bank, output dsp_bank_sel,
                  input host_a_ok, input host_b_ok);
    modport route (input adaptive, input dsp_run, input active_bank, input dsp_bank_sel,
                   output host_a_ok, output host_b_ok);
endinterface

`default_nettype wire

// File: cra_bank_route.sv
`timescale 1ns/1ps
`default_nettype none

module cra_bank_route (
    cra_bank_if.route bus
);
    // ------------------------------------------------------------------
    // Host reach per bank
    // ------------------------------------------------------------------
    always_comb begin
        bus.host_a_ok = 1'b0;
        bus.host_b_ok = 1'b0;
        if (bus.adaptive) begin
            if (!bus.dsp_run) begin
                bus.host_a_ok = 1'b1;
            end else begin
                bus.host_a_ok = bus.active_bank;
                bus.host_b_ok = !bus.active_bank;
            end
        end else if (!bus.dsp_run) begin
            bus.host_a_ok = 1'b1;
            bus.host_b_ok = 1'b1;
        end
        // Processor running without adaptive mode leaves both closed.
    end
endmodule

`default_nettype wire

// File: cra_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

module cra_arbiter #(
    parameter int RAMP_NORMAL_CYCLES = cra_pkg::RAMP_NORMAL_CYC,
    parameter int RAMP_FAST_CYCLES   = cra_pkg::RAMP_FAST_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_page,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       dsp_run,
    input  wire logic       dsp_bank_sel,
    input  wire logic       dsp_frame_edge,
    input  wire logic       host_req_bank,
    input  wire logic       host_req,
    output logic            host_grant,
    output logic            host_deny,
    output logic            dsp_bank,
    output logic            ref_ramp_fast,
    output logic            ref_ready
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic          ramp_fast_q;
    logic          adaptive_q;
    logic          switch_req_q;
    logic          active_bank_q;
    logic [31:0]   ramp_cnt;
    logic [31:0]   ramp_limit;
    cra_pkg::cra_sw_state_t sw_state;
    cra_pkg::cra_sw_state_t next_sw_state;
    cra_bank_if    bus ();

    function automatic logic hit(input logic [7:0] pg, input logic [7:0] ad,
                                 input logic [7:0] p, input logic [7:0] a);
        return (pg == p) && (ad == a);
    endfunction

    wire logic wr_ramp = reg_wr && hit(reg_page, reg_addr, cra_pkg::REF_RAMP_PAGE, cra_pkg::REF_RAMP_OFFSET);
    wire logic wr_bank = reg_wr && hit(reg_page, reg_addr, cra_pkg::BANK_CTRL_PAGE, cra_pkg::BANK_CTRL_OFFSET);

    always_ff @(posedge mclk) begin
        if (rst) begin
            ramp_fast_q <= cra_pkg::REF_RAMP_FAST_RST;
        end else if (wr_ramp) begin
            ramp_fast_q <= reg_wdata[cra_pkg::REF_RAMP_FAST_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            adaptive_q <= cra_pkg::ADAPTIVE_RST;
        end else if (wr_bank) begin
            adaptive_q <= reg_wdata[cra_pkg::ADAPTIVE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Bank exchange
    // ------------------------------------------------------------------
    // The exchange waits for a processor frame boundary so coefficients never
    // change under a running filter; a stopped processor swaps at once.
    always_comb begin
        next_sw_state = sw_state;
        case (sw_state)
            cra_pkg::CRA_SW_IDLE: begin
                if (switch_req_q) begin
                    next_sw_state = cra_pkg::CRA_SW_WAIT;
                end
            end
            cra_pkg::CRA_SW_WAIT: begin
                if (dsp_frame_edge || !dsp_run) begin
                    next_sw_state = cra_pkg::CRA_SW_DONE;
                end
            end
            cra_pkg::CRA_SW_DONE: begin
                next_sw_state = cra_pkg::CRA_SW_IDLE;
            end
            default: begin
                next_sw_state = cra_pkg::CRA_SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sw_state <= cra_pkg::CRA_SW_IDLE;
        end else begin
            sw_state <= next_sw_state;
        end
    end

    // A new request written in the completing cycle wins over the clear.
    always_ff @(posedge mclk) begin
        if (rst) begin
            switch_req_q <= cra_pkg::SWITCH_REQ_RST;
        end else if (wr_bank && reg_wdata[cra_pkg::SWITCH_REQ_BIT]) begin
            switch_req_q <= 1'b1;
        end else if (sw_state == cra_pkg::CRA_SW_DONE) begin
            switch_req_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            active_bank_q <= cra_pkg::ACTIVE_BANK_RST;
        end else if (sw_state == cra_pkg::CRA_SW_DONE) begin
            active_bank_q <= !active_bank_q;
        end
    end

    // ------------------------------------------------------------------
    // Routing
    // ------------------------------------------------------------------
    assign bus.adaptive     = adaptive_q;
    assign bus.dsp_run      = dsp_run;
    assign bus.active_bank  = active_bank_q;
    assign bus.dsp_bank_sel = dsp_bank_sel;

    cra_bank_route u_route (
        .bus (bus)
    );

    // One lookup feeds both answers, so a request can never be granted and denied at once.
    wire logic host_ok = host_req_bank ? bus.host_b_ok : bus.host_a_ok;

    always_ff @(posedge mclk) begin
        if (rst) begin
            host_grant <= 1'b0;
            host_deny  <= 1'b0;
        end else begin
            host_grant <= host_req && host_ok;
            host_deny  <= host_req && !host_ok;
        end
    end

    // Adaptive mode pins the processor to the active bank; otherwise it picks.
    always_ff @(posedge mclk) begin
        if (rst) begin
            dsp_bank <= 1'b0;
        end else begin
            dsp_bank <= adaptive_q ? active_bank_q : dsp_bank_sel;
        end
    end

    // ------------------------------------------------------------------
    // Reference ramp timer
    // ------------------------------------------------------------------
    // The ramp restarts on any write to the speed bit; the timer only models
    // settling, the analog reference itself lives outside.
    always_ff @(posedge mclk) begin
        if (rst || wr_ramp) begin
            ramp_cnt <= 32'h0000_0000;
        end else if (!ref_ready) begin
            ramp_cnt <= ramp_cnt + 32'h0000_0001;
        end
    end

    // The limit follows the speed bit in force; a speed write restarts the count, so a change
    // of limit never lands in the middle of a ramp.
    always_comb begin
        ramp_limit = 32'(RAMP_NORMAL_CYCLES);
        if (ramp_fast_q) begin
            ramp_limit = 32'(RAMP_FAST_CYCLES);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || wr_ramp) begin
            ref_ready <= 1'b0;
        end else begin
            ref_ready <= ramp_cnt >= ramp_limit;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_ramp_fast <= 1'b0;
        end else begin
            ref_ramp_fast <= ramp_fast_q;
        end
    end

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    // Read-only bits have no write path, so host writes cannot move them.
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= 8'h00;
            if (hit(reg_page, reg_addr, cra_pkg::REF_RAMP_PAGE, cra_pkg::REF_RAMP_OFFSET)) begin
                reg_rdata[cra_pkg::REF_RAMP_FAST_BIT] <= ramp_fast_q;
            end else if (hit(reg_page, reg_addr, cra_pkg::BANK_CTRL_PAGE, cra_pkg::BANK_CTRL_OFFSET)) begin
                reg_rdata[cra_pkg::BANK_MONITOR_BIT] <= dsp_bank;
                reg_rdata[cra_pkg::ADAPTIVE_BIT]     <= adaptive_q;
                reg_rdata[cra_pkg::ACTIVE_BANK_BIT]  <= active_bank_q;
                reg_rdata[cra_pkg::SWITCH_REQ_BIT]   <= switch_req_q;
            end
        end
    end
endmodule

`default_nettype wire

// File: cra_arbiter_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks
// ------------------------------------------------------------
module cra_arbiter_monitor (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       dsp_run,
    input wire logic       host_req,
    input wire logic       host_req_bank,
    input wire logic       host_grant,
    input wire logic       host_deny,
    input wire logic       dsp_bank,
    input wire logic       ref_ramp_fast
);
    // The mode bit is rebuilt from host writes, since it never reaches a port.
    logic      adp;
    wire logic rh = reg_page == 8'h01 && reg_addr == 8'h08;
    wire logic bh = reg_page == 8'h2c && reg_addr == 8'h01;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk) begin
        if (rst)
            adp <= 1'b0;
        else if (reg_wr && bh)
            adp <= reg_wdata[2];
    end
    AST_OPEN: assert property (host_req && !adp && !dsp_run |=> host_grant && !host_deny)
        else $error("grant expected when stopped");
    AST_SHUT: assert property (host_req && !adp && dsp_run |=> host_deny && !host_grant)
        else $error("deny expected when running");
    AST_ONLY_A: assert property (host_req && adp && !dsp_run |=> host_grant == !$past(host_req_bank))
        else $error("only bank A reachable");
    AST_ONE_ANSWER: assert property (host_req |=> host_grant != host_deny)
        else $error("one answer per request");
    AST_FAST: assert property (reg_wr && rh |=> ##1 ref_ramp_fast == $past(reg_wdata[4], 2))
        else $error("ramp speed not taken");
    AST_RAMP_RD: assert property (reg_rd && rh && !reg_wr |=> reg_rdata == {3'h0, ref_ramp_fast, 4'h0})
        else $error("ramp read wrong");
    AST_MON: assert property (reg_rd && bh && !adp |=> reg_rdata[3] == $past(dsp_bank))
        else $error("monitor bit wrong");
    AST_ADP: assert property (reg_rd && bh && !reg_wr |=> reg_rdata[2] == adp && reg_rdata[7:4] == 4'h0)
        else $error("mode bit wrong");
    AST_UNMAP: assert property (reg_rd && reg_page == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind cra_arbiter cra_arbiter_monitor u_mon (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dsp_run(dsp_run), .host_req(host_req), .host_req_bank(host_req_bank), .host_grant(host_grant),
    .host_deny(host_deny), .dsp_bank(dsp_bank), .ref_ramp_fast(ref_ramp_fast));
`default_nettype wire

// File: cra_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host side of the control port
// ------------------------------------------------------------
module cra_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       host_grant,
    input  wire logic       host_deny,
    output var  logic       reg_wr = 1'b0,
    output var  logic       reg_rd = 1'b0,
    output var  logic [7:0] reg_page = 8'h00,
    output var  logic [7:0] reg_addr = 8'h00,
    output var  logic [7:0] reg_wdata = 8'h00,
    output var  logic       host_req = 1'b0,
    output var  logic       host_req_bank = 1'b0
);
    // Released lines show the inverse of their last value so stale data cannot pass.
    task automatic wr(input logic [15:0] pa, input logic [7:0] d);
        @(posedge mclk);
        {reg_page, reg_addr, reg_wdata} <= {pa, d};
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        {reg_page, reg_addr, reg_wdata} <= ~{pa, d};
    endtask
    task automatic rd(input logic [15:0] pa, output logic [7:0] d);
        @(posedge mclk);
        {reg_page, reg_addr} <= pa;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        {reg_page, reg_addr} <= ~pa;
        #1;
        d = reg_rdata;
    endtask
    task automatic req(input logic b, output logic [7:0] gd);
        @(posedge mclk);
        host_req_bank <= b;
        host_req <= 1'b1;
        @(posedge mclk);
        host_req <= 1'b0;
        host_req_bank <= ~b;
        #1;
        gd = {6'h00, host_grant, host_deny};
    endtask
endmodule
`default_nettype wire

// File: test_coef_ram_access_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Directed bench
// ------------------------------------------------------------
module test_coef_ram_access_arbiter;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       dsp_run = 1'b0;
    logic       dsp_bank_sel = 1'b0;
    logic       dsp_frame_edge = 1'b0;
    wire logic  reg_wr, reg_rd, host_req, host_req_bank, host_grant, host_deny;
    wire logic  dsp_bank, ref_ramp_fast, ref_ready;
    wire logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata;
    logic [7:0] d;
    int         cyc;
    int         bad_count = 0;
    int         n_tests = 0;
    initial forever #2.5 mclk = ~mclk;
    // Short ramps keep the run small while both speeds are still timed.
    cra_arbiter #(.RAMP_NORMAL_CYCLES(100), .RAMP_FAST_CYCLES(20)) dut (.mclk(mclk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .dsp_run(dsp_run), .dsp_bank_sel(dsp_bank_sel), .dsp_frame_edge(dsp_frame_edge),
        .host_req_bank(host_req_bank), .host_req(host_req), .host_grant(host_grant), .host_deny(host_deny),
        .dsp_bank(dsp_bank), .ref_ramp_fast(ref_ramp_fast), .ref_ready(ref_ready));
    cra_host_model host (.mclk(mclk), .reg_rdata(reg_rdata), .host_grant(host_grant), .host_deny(host_deny),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .host_req(host_req), .host_req_bank(host_req_bank));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic dsp(input logic r, input logic s);
        @(posedge mclk);
        dsp_run <= r;
        dsp_bank_sel <= s;
    endtask
    task automatic banks(input logic [7:0] a, input logic [7:0] b);
        host.req(1'b0, d);
        chk(d, a);
        host.req(1'b1, d);
        chk(d, b);
    endtask
    // A wait that runs out leaves cyc at its bound, which the following compare counts as a mismatch.
    task automatic wait_ready();
        cyc = 0;
        while (ref_ready !== 1'b1 && cyc < 200) begin
            @(posedge mclk);
            cyc++;
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        host.rd(16'h0108, d);
        chk(d, 8'h00);
        wait_ready();
        chk({7'h00, cyc > 90 && cyc < 110}, 8'h01);
        host.wr(16'h0108, 8'h10);
        host.rd(16'h0108, d);
        chk(d, 8'h10);
        chk({6'h00, ref_ramp_fast, ref_ready}, 8'h02);
        wait_ready();
        chk({7'h00, cyc > 15 && cyc < 25}, 8'h01);
        host.wr(16'h0108, 8'h00);
        host.rd(16'h0108, d);
        chk(d, 8'h00);
        host.rd(16'h0008, d);
        chk(d, 8'h00);
        host.rd(16'h2c01, d);
        chk(d, 8'h00);
        banks(8'h02, 8'h02);
        dsp(1'b1, 1'b1);
        banks(8'h01, 8'h01);
        host.rd(16'h2c01, d);
        chk(d, 8'h08);
        dsp(1'b1, 1'b0);
        host.wr(16'h2c01, 8'h0a);
        host.rd(16'h2c01, d);
        chk(d, 8'h00);
        dsp(1'b0, 1'b0);
        host.wr(16'h2c01, 8'h04);
        banks(8'h02, 8'h01);
        dsp(1'b1, 1'b0);
        banks(8'h01, 8'h02);
        host.wr(16'h2c01, 8'h05);
        host.rd(16'h2c01, d);
        chk(d & 8'hf7, 8'h05);
        host.wr(16'h2c01, 8'h04);
        host.rd(16'h2c01, d);
        chk(d & 8'hf7, 8'h05);
        @(posedge mclk);
        dsp_frame_edge <= 1'b1;
        @(posedge mclk);
        dsp_frame_edge <= 1'b0;
        repeat (3) @(posedge mclk);
        host.rd(16'h2c01, d);
        chk(d & 8'hf7, 8'h06);
        chk({7'h00, dsp_bank}, 8'h01);
        banks(8'h02, 8'h01);
        dsp(1'b0, 1'b0);
        host.wr(16'h2c01, 8'h05);
        repeat (3) @(posedge mclk);
        host.rd(16'h2c01, d);
        chk(d & 8'hf7, 8'h04);
        chk({7'h00, dsp_bank}, 8'h00);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        host.rd(16'h2c01, d);
        chk(d, 8'h00);
        host.rd(16'h0108, d);
        chk({d[7:1], ref_ready}, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
